// File: src/tmcs_top.sv
// Torque mode command selection, shaping, speed cap and torque outputs
// Functional notes
// - Torque control runs only while the mode setting holds 2.
// - Source setting picks analog, internal presets, or analog mixed with presets.
// - Channel setting routes one analog input to speed, the other to torque.
// - Internal source: two select inputs choose one of four presets.
// - Mixed source: both selects low passes analog, else presets two to four.
// - Active inhibit input forces the torque command to zero.
// - Active invert input flips the torque command sign.
// - Analog torque is scaled by a gain in percent per volt, default 30.
// - Second analog input is low-pass filtered, 0.20 to 50.00 ms, default 2.00.
// - Analog command has a dead zone of 0 to 13000 mV.
// - Second analog input gets a zero offset of -1500.0 to 1500.0 mV.
// - Writing 1 or 2 calibrates the offset of input one or two.
// - Analog torque has a direction bit and a three-way polarity setting.
// - Torque output follows the selected command proportionally.
// - Speed is capped at the torque mode cap, default 3000 r/min.
// - Limit select 0 uses only the torque mode cap.
// - Limit select 1 also limits by the analog speed command.
// - Limit select 2 also limits by the chosen internal speed preset.
// - Torque reached output has threshold, hysteresis and polarity.
// - Speed limited output is high while the speed cap holds the motor.
// - Input one is servo enable, output one is servo ready.
// - Ignore setting 3 disregards both overtravel inputs.
`timescale 1ns/1ns
`include "tmcs_params.svh"
module tmcs_top #(
  parameter int ANA_W = 18,
  parameter int SPD_RPM_PER_V = 500
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire tmcs_pkg::tmcs_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Analog samples in mV, same clock
  input wire tmcs_pkg::tmcs_ana_t analog_input_one,
  input wire tmcs_pkg::tmcs_ana_t analog_input_two,
  // Motor feedback, same clock
  input wire logic signed [15:0] actual_torque,
  input wire logic signed [15:0] actual_speed,
  // Digital input pins
  input wire logic servo_enable_in,
  input wire logic torque_preset_sel_lo,
  input wire logic torque_preset_sel_hi,
  input wire logic speed_preset_sel_lo,
  input wire logic speed_preset_sel_hi,
  input wire logic command_inhibit_in,
  input wire logic command_invert,
  input wire logic forward_overtravel_in,
  input wire logic reverse_overtravel_in,
  // Command and status outputs
  output logic signed [15:0] torque_cmd,
  output logic [15:0] speed_limit,
  output logic torque_mode_active,
  output logic torque_reached_out,
  output logic speed_limited_out,
  output logic servo_ready_out,
  output logic forward_drive_prohibit,
  output logic reverse_drive_prohibit
);
  import tmcs_pkg::*;

  // ***********************************************
  // Declarations
  // ***********************************************
  localparam int NDI = 9;
  tmcs_word_t cfg_q [0:22];
  logic [NDI-1:0] di_raw;
  logic [NDI-1:0] di_m_q;
  logic [NDI-1:0] di_q;
  tmcs_ana_t cal1_q;
  tmcs_ana_t cal2_q;
  tmcs_ana_t as1_adj_q;
  tmcs_ana_t as2_adj_q;
  tmcs_ana_t trq_ana;
  tmcs_ana_t spd_ana;
  tmcs_ana_t shaped_q;
  logic signed [35:0] gain_prod;
  logic signed [15:0] ana_trq_q;
  logic signed [15:0] sel_d;
  logic signed [15:0] sel_q;
  logic signed [15:0] mod_d;
  logic signed [15:0] mod_q;
  logic signed [15:0] trq_q;
  logic signed [15:0] spd_ana_rpm;
  logic [15:0] lim_d;
  logic [15:0] lim_q;
  logic [15:0] spd_mag;
  logic over_spd;
  logic limited_q;
  logic reached_q;
  logic ready_q;
  logic mode_q;
  logic fwd_proh;
  logic rev_proh;
  logic [15:0] rdata_q;
  logic [1:0] tsel;
  logic [1:0] ssel;
  tmcs_src_t src;
  tmcs_filt_if flt_if ();

  // Sign extension of a 16-bit setting to the analog width
  function automatic tmcs_ana_t ext(input tmcs_word_t w);
    ext = {{2{w[15]}}, w};
  endfunction : ext

  // Magnitude of a signed word, returned unsigned so the most negative value gives 16'h8000
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  assign di_raw = {servo_enable_in, reverse_overtravel_in, forward_overtravel_in,
                   command_invert, command_inhibit_in, speed_preset_sel_hi,
                   speed_preset_sel_lo, torque_preset_sel_hi, torque_preset_sel_lo};

  // Two flops per input pin
  for (genvar g = 0; g < NDI; g++) begin : g_sync
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        di_m_q[g] <= 1'b0;
        di_q[g] <= 1'b0;
      end else begin
        di_m_q[g] <= di_raw[g];
        di_q[g] <= di_m_q[g];
      end
    end
  end

  assign tsel = di_q[1:0];
  assign ssel = di_q[3:2];

  // ***********************************************
  // Settings
  // ***********************************************
  // Settings written from the register port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 23; i++) begin
        cfg_q[i] <= 16'h0000;
      end
      cfg_q[`TMCS_R_TAU] <= `TMCS_RST_TAU;
      cfg_q[`TMCS_R_GAIN] <= `TMCS_RST_GAIN;
      cfg_q[`TMCS_R_SCAP] <= `TMCS_RST_SCAP;
      cfg_q[`TMCS_R_IGNOT] <= `TMCS_RST_IGNOT;
    end else if (reg_wr && reg_addr < `TMCS_NCFG) begin
      cfg_q[reg_addr] <= reg_wdata;
    end
  end

  // Offset calibration captures the negated raw sample
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal1_q <= '0;
      cal2_q <= '0;
    end else if (reg_wr && reg_addr == `TMCS_R_CAL) begin
      if (reg_wdata == `TMCS_CAL_AS1) begin
        cal1_q <= -analog_input_one;
      end
      if (reg_wdata == `TMCS_CAL_AS2) begin
        cal2_q <= -analog_input_two;
      end
    end
  end

  // ***********************************************
  // Analog conditioning
  // ***********************************************
  // Zero offset, manual in 0.1 mV plus calibration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      as1_adj_q <= '0;
      as2_adj_q <= '0;
    end else begin
      as1_adj_q <= analog_input_one + cal1_q
                   + ext(cfg_q[`TMCS_R_OFF1]) / 18'sd10;
      as2_adj_q <= analog_input_two + cal2_q
                   + ext(cfg_q[`TMCS_R_OFF2]) / 18'sd10;
    end
  end

  assign flt_if.sample = as2_adj_q;
  assign flt_if.tau = cfg_q[`TMCS_R_TAU];

  tmcs_lpf u_lpf (
    .clk(clk),
    .sys_rst(sys_rst),
    .lp(flt_if.flt)
  );

  // Channel routing between speed and torque
  assign trq_ana = cfg_q[`TMCS_R_CHAN][0] ? as1_adj_q : flt_if.smooth;
  assign spd_ana = cfg_q[`TMCS_R_CHAN][0] ? flt_if.smooth : as1_adj_q;

  // Dead zone, direction and polarity
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shaped_q <= '0;
    end else if (trq_ana <= ext(cfg_q[`TMCS_R_DZONE])
                 && trq_ana >= -ext(cfg_q[`TMCS_R_DZONE])) begin
      shaped_q <= '0;
    end else if (cfg_q[`TMCS_R_DIRPOL][2:1] == 2'h1 && trq_ana[ANA_W-1]) begin
      shaped_q <= '0;
    end else if (cfg_q[`TMCS_R_DIRPOL][2:1] == 2'h2 && !trq_ana[ANA_W-1]) begin
      shaped_q <= '0;
    end else if (cfg_q[`TMCS_R_DIRPOL][0]) begin
      shaped_q <= -trq_ana;
    end else begin
      shaped_q <= trq_ana;
    end
  end

  // Gain in percent per volt on a mV sample
  assign gain_prod = shaped_q * $signed({2'b00, cfg_q[`TMCS_R_GAIN]});

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ana_trq_q <= '0;
    end else begin
      ana_trq_q <= 16'(gain_prod / 36'sd1000);
    end
  end

  // ***********************************************
  // Source selection and command modifiers
  // ***********************************************
  assign src = tmcs_src_t'(cfg_q[`TMCS_R_SRC][1:0]);

  // Analog, preset, or mixed
  always_comb begin
    sel_d = '0;
    unique case (src)
      TMCS_SRC_ANALOG: sel_d = ana_trq_q;
      TMCS_SRC_PRESET: sel_d = cfg_q[`TMCS_R_TORQUE_PRESET_SEL_LO + 5'(tsel)];
      TMCS_SRC_MIXED: begin
        if (tsel == 2'b00) begin
          sel_d = ana_trq_q;
        end else begin
          sel_d = cfg_q[`TMCS_R_TORQUE_PRESET_SEL_LO + 5'(tsel)];
        end
      end
      default: sel_d = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_q <= '0;
    end else begin
      sel_q <= sel_d;
    end
  end

  // Inhibit wins over inversion
  always_comb begin
    if (di_q[4]) begin
      mod_d = '0;
    end else if (di_q[5]) begin
      mod_d = -sel_q;
    end else begin
      mod_d = sel_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mod_q <= '0;
    end else begin
      mod_q <= mod_d;
    end
  end

  // ***********************************************
  // Speed limit
  // ***********************************************
  assign spd_ana_rpm = 16'(spd_ana * SPD_RPM_PER_V / 1000);

  // Basic cap, tightened by analog or preset speed
  always_comb begin
    lim_d = cfg_q[`TMCS_R_SCAP];
    if (cfg_q[`TMCS_R_SLSEL][1:0] == 2'h1 && mag(spd_ana_rpm) < lim_d) begin
      lim_d = mag(spd_ana_rpm);
    end
    if (cfg_q[`TMCS_R_SLSEL][1:0] == 2'h2
        && mag(cfg_q[`TMCS_R_SPD1 + 5'(ssel)]) < lim_d) begin
      lim_d = mag(cfg_q[`TMCS_R_SPD1 + 5'(ssel)]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lim_q <= `TMCS_RST_SCAP;
    end else begin
      lim_q <= lim_d;
    end
  end

  assign spd_mag = mag(actual_speed);
  // Cap holds when speed is over and torque pushes further
  assign over_spd = spd_mag > lim_q && mod_q != 16'sh0000
                    && mod_q[15] == actual_speed[15];

  // ***********************************************
  // Mode, enable and overtravel
  // ***********************************************
  assign fwd_proh = di_q[6] && !cfg_q[`TMCS_R_IGNOT][0];
  assign rev_proh = di_q[7] && !cfg_q[`TMCS_R_IGNOT][1];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      mode_q <= cfg_q[`TMCS_R_MODE] == `TMCS_MODE_TORQUE;
      ready_q <= 1'b1;
    end
  end

  // Final torque command register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trq_q <= '0;
      limited_q <= 1'b0;
    end else if (!mode_q || !di_q[8]) begin
      trq_q <= '0;
      limited_q <= 1'b0;
    end else if ((fwd_proh && !mod_q[15]) || (rev_proh && mod_q[15])) begin
      trq_q <= '0;
      limited_q <= 1'b0;
    end else if (over_spd) begin
      trq_q <= '0;
      limited_q <= 1'b1;
    end else begin
      trq_q <= mod_q;
      limited_q <= 1'b0;
    end
  end

  // ***********************************************
  // Torque reached comparator
  // ***********************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reached_q <= 1'b0;
    end else if (actual_torque > $signed(cfg_q[`TMCS_R_RTHR])) begin
      reached_q <= 1'b1;
    end else if (actual_torque < $signed(cfg_q[`TMCS_R_RTHR] - cfg_q[`TMCS_R_RHYS])) begin
      reached_q <= 1'b0;
    end
  end

  // ***********************************************
  // Read port
  // ***********************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr < `TMCS_NCFG) begin
        rdata_q <= cfg_q[reg_addr];
      end else begin
        unique case (reg_addr)
          `TMCS_R_STAT: rdata_q <= {9'h000, di_q[8], ready_q, rev_proh, fwd_proh,
                                    limited_q, reached_q, mode_q};
          `TMCS_R_TCMD: rdata_q <= trq_q;
          `TMCS_R_CAL1: rdata_q <= cal1_q[15:0];
          `TMCS_R_CAL2: rdata_q <= cal2_q[15:0];
          default: rdata_q <= 16'h0000;
        endcase
      end
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  assign reg_rdata = rdata_q;
  assign torque_cmd = trq_q;
  assign speed_limit = lim_q;
  assign torque_mode_active = mode_q;
  assign torque_reached_out = reached_q ^ cfg_q[`TMCS_R_RPOL][0];
  assign speed_limited_out = limited_q;
  assign servo_ready_out = ready_q;
  assign forward_drive_prohibit = fwd_proh;
  assign reverse_drive_prohibit = rev_proh;
endmodule : tmcs_top

// File: src/tmcs_params.svh
// Offsets, field values, reset values and timing counts of the torque command block
`ifndef TMCS_PARAMS_SVH
`define TMCS_PARAMS_SVH

// ***********************************************
// Register indices
// ***********************************************
`define TMCS_R_MODE 5'h00
`define TMCS_R_CHAN 5'h01
`define TMCS_R_SRC 5'h02
`define TMCS_R_TAU 5'h03
`define TMCS_R_DZONE 5'h04
`define TMCS_R_OFF1 5'h05
`define TMCS_R_OFF2 5'h06
`define TMCS_R_GAIN 5'h07
`define TMCS_R_DIRPOL 5'h08
`define TMCS_R_TORQUE_PRESET_SEL_LO 5'h09
`define TMCS_R_SLSEL 5'h0d
`define TMCS_R_SCAP 5'h0e
`define TMCS_R_SPD1 5'h0f
`define TMCS_R_RTHR 5'h13
`define TMCS_R_RHYS 5'h14
`define TMCS_R_RPOL 5'h15
`define TMCS_R_IGNOT 5'h16
`define TMCS_NCFG 5'h17
`define TMCS_R_CAL 5'h17
`define TMCS_R_STAT 5'h18
`define TMCS_R_TCMD 5'h19
`define TMCS_R_CAL1 5'h1a
`define TMCS_R_CAL2 5'h1b

// ***********************************************
// Field values and reset values
// ***********************************************
`define TMCS_MODE_TORQUE 16'h0002
`define TMCS_CAL_AS1 16'h0001
`define TMCS_CAL_AS2 16'h0002
`define TMCS_RST_TAU 16'h00c8
`define TMCS_MIN_TAU 16'h0014
`define TMCS_RST_GAIN 16'h001e
`define TMCS_RST_SCAP 16'h0bb8
`define TMCS_RST_IGNOT 16'h0003
`define TMCS_GAIN_DIV 1000
`define TMCS_OFF_DIV 10

// ***********************************************
// Timing
// ***********************************************
`define TMCS_CLK_NS 40
`define TMCS_FILT_STEP_NS 10000
`define TMCS_FILT_STEP_CYC (`TMCS_FILT_STEP_NS / `TMCS_CLK_NS)

`endif

// File: src/tmcs_pkg.sv
// Types shared by the torque command block
package tmcs_pkg;
  typedef logic signed [17:0] tmcs_ana_t;
  typedef logic [15:0] tmcs_word_t;
  typedef enum logic [1:0] {TMCS_SRC_ANALOG, TMCS_SRC_PRESET, TMCS_SRC_MIXED} tmcs_src_t;
endpackage : tmcs_pkg

// File: src/tmcs_filt_if.sv
// Link between the command path and its low-pass filter
`timescale 1ns/1ns
interface tmcs_filt_if;
  import tmcs_pkg::*;
  tmcs_ana_t sample;
  tmcs_word_t tau;
  tmcs_ana_t smooth;
  modport drv (output sample, output tau, input smooth);
  modport flt (input sample, input tau, output smooth);
endinterface : tmcs_filt_if

// File: src/tmcs_lpf.sv
// First-order low-pass filter for the second analog input
`timescale 1ns/1ns
`include "tmcs_params.svh"
module tmcs_lpf #(
  parameter int STEP = `TMCS_FILT_STEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Filter link
  tmcs_filt_if.flt lp
);
  import tmcs_pkg::*;

  localparam int TW = $clog2(STEP + 1);
  localparam logic [TW-1:0] STEP_LAST = TW'(STEP - 1);

  logic [TW-1:0] tick_q;
  logic signed [33:0] acc_q;
  logic signed [33:0] diff;
  tmcs_word_t tau_c;

  // Time constant in 10 us steps, kept at or above the low bound
  assign tau_c = (lp.tau < `TMCS_MIN_TAU) ? `TMCS_MIN_TAU : lp.tau;
  assign diff = {lp.sample, 16'h0000} - acc_q;

  // Step tick every 10 us
  always_ff @(posedge clk) begin
    if (sys_rst || tick_q == STEP_LAST) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  // Accumulator moves 1/tau of the error each step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= '0;
    end else if (tick_q == STEP_LAST) begin
      acc_q <= acc_q + diff / $signed({18'h00000, tau_c});
    end
  end

  assign lp.smooth = acc_q[33:16];
endmodule : tmcs_lpf

// File: tb/tmcs_monitor.sv
// Port checker of the torque command block
`timescale 1ns/1ns
`include "tmcs_params.svh"
module tmcs_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Pins
  input wire logic servo_enable_in,
  input wire logic command_inhibit_in,
  input wire logic forward_overtravel_in,
  // Outputs
  input wire logic signed [15:0] torque_cmd,
  input wire logic [15:0] speed_limit,
  input wire logic torque_mode_active,
  input wire logic speed_limited_out,
  input wire logic servo_ready_out,
  input wire logic forward_drive_prohibit,
  input wire logic reverse_drive_prohibit
);
  // ***********************************************
  // Properties
  // ***********************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Read strobe naming one register
  sequence s_rd(logic [4:0] a);
    reg_rd && reg_addr == a;
  endsequence
  property p_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer cycle");
  property p_rst;
    disable iff (1'b0) sys_rst |=> speed_limit == 16'h0bb8 && torque_cmd == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_ready;
    !sys_rst ##1 !sys_rst |-> servo_ready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("ready low after reset");
  property p_mode;
    !torque_mode_active [*4] |-> torque_cmd == 16'h0000;
  endproperty
  a_mode: assert property (p_mode) else $error("torque outside torque mode");
  property p_enable;
    !servo_enable_in [*8] |-> torque_cmd == 16'h0000;
  endproperty
  a_enable: assert property (p_enable) else $error("torque while disabled");
  property p_inh;
    command_inhibit_in [*8] |-> torque_cmd == 16'h0000;
  endproperty
  a_inh: assert property (p_inh) else $error("torque while inhibited");
  property p_ot;
    !forward_overtravel_in [*4] |-> !forward_drive_prohibit;
  endproperty
  a_ot: assert property (p_ot) else $error("prohibit without overtravel");
  property p_proh;
    forward_drive_prohibit [*6] |-> torque_cmd <= 16'sh0000;
  endproperty
  a_proh: assert property (p_proh) else $error("forward torque while prohibited");
  property p_lim;
    speed_limited_out [*3] |-> torque_cmd == 16'h0000;
  endproperty
  a_lim: assert property (p_lim) else $error("torque while speed limited");
  property p_tcmd;
    s_rd(`TMCS_R_TCMD) |=> reg_rdata == $past(torque_cmd);
  endproperty
  a_tcmd: assert property (p_tcmd) else $error("command read mismatch");
  property p_stat;
    s_rd(`TMCS_R_STAT) |=> reg_rdata[5:2] == $past({servo_ready_out, reverse_drive_prohibit,
      forward_drive_prohibit, speed_limited_out}) && reg_rdata[0] == $past(torque_mode_active);
  endproperty
  a_stat: assert property (p_stat) else $error("status read mismatch");
endmodule : tmcs_monitor
bind tmcs_top tmcs_monitor u_mon (.clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata,
  .servo_enable_in, .command_inhibit_in, .forward_overtravel_in, .torque_cmd, .speed_limit,
  .torque_mode_active, .speed_limited_out, .servo_ready_out, .forward_drive_prohibit,
  .reverse_drive_prohibit);

// File: tb/tmcs_host_model.sv
// Host controller model driving pins, analog samples and motor feedback
`timescale 1ns/1ns
module tmcs_host_model (
  // Clock
  input wire logic clk,
  // Towards the drive
  output logic [8:0] pins,
  output tmcs_pkg::tmcs_ana_t ana_one,
  output tmcs_pkg::tmcs_ana_t ana_two,
  output logic signed [15:0] fb_torque,
  output logic signed [15:0] fb_speed
);
  import tmcs_pkg::*;
  // Idle levels from time zero
  initial begin
    pins = 9'h000;
    ana_one = 18'h00000;
    ana_two = 18'h00000;
    fb_torque = 16'h0000;
    fb_speed = 16'h0000;
  end
  // Each change lands just after a rising edge
  task automatic set_pins(input logic [8:0] p);
    @(posedge clk);
    pins <= p;
  endtask : set_pins
  task automatic set_ana(input tmcs_ana_t a, input tmcs_ana_t b);
    @(posedge clk);
    ana_one <= a;
    ana_two <= b;
  endtask : set_ana
  task automatic set_fb(input logic signed [15:0] t, input logic signed [15:0] s);
    @(posedge clk);
    fb_torque <= t;
    fb_speed <= s;
  endtask : set_fb
endmodule : tmcs_host_model

// File: tb/tb.sv
// Testbench of the torque command block
`timescale 1ns/1ns
`include "tmcs_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import tmcs_pkg::*;
  logic clk = 1'b0;
  logic sys_rst;
  logic [4:0] reg_addr;
  tmcs_word_t reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [8:0] pins;
  tmcs_ana_t ana_one;
  tmcs_ana_t ana_two;
  logic signed [15:0] fb_torque;
  logic signed [15:0] fb_speed;
  logic signed [15:0] torque_cmd;
  logic [15:0] speed_limit;
  logic mode_act, reached, limited, ready, fproh, rproh;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [15:0] pv [4] = '{16'h000a, 16'hffec, 16'h0096, 16'hfed4};
  // ***********************************************
  // Clock, partner and design
  // ***********************************************
  always #20 clk = ~clk;
  tmcs_host_model u_host (.clk, .pins, .ana_one, .ana_two, .fb_torque, .fb_speed);
  tmcs_top u_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .analog_input_one(ana_one), .analog_input_two(ana_two), .actual_torque(fb_torque),
    .actual_speed(fb_speed), .servo_enable_in(pins[0]), .torque_preset_sel_lo(pins[1]),
    .torque_preset_sel_hi(pins[2]), .speed_preset_sel_lo(pins[3]),
    .speed_preset_sel_hi(pins[4]), .command_inhibit_in(pins[5]), .command_invert(pins[6]),
    .forward_overtravel_in(pins[7]), .reverse_overtravel_in(pins[8]), .torque_cmd,
    .speed_limit, .torque_mode_active(mode_act), .torque_reached_out(reached),
    .speed_limited_out(limited), .servo_ready_out(ready), .forward_drive_prohibit(fproh),
    .reverse_drive_prohibit(rproh));
  // ***********************************************
  // Tasks
  // ***********************************************
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rc
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 45000) begin
      fails++;
      complete_run();
    end
  end
  // ***********************************************
  // Tests
  // ***********************************************
  initial begin
    sys_rst = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    w(2);
    `CHK(speed_limit, 16'h0bb8)
    `CHK(ready, 1'b1)
    `CHK(mode_act, 1'b0)
    rc(`TMCS_R_TAU, 16'h00c8);
    rc(`TMCS_R_GAIN, 16'h001e);
    rc(`TMCS_R_SCAP, 16'h0bb8);
    rc(`TMCS_R_IGNOT, 16'h0003);
    rc(5'h1f, 16'h0000);
    $display("test reset done");
    u_host.set_pins(9'h001);
    wr(`TMCS_R_MODE, `TMCS_MODE_TORQUE);
    wr(`TMCS_R_SRC, 16'h0001);
    for (int i = 0; i < 4; i++) wr(5'(`TMCS_R_TORQUE_PRESET_SEL_LO + i), pv[i]);
    for (int i = 0; i < 4; i++) begin
      u_host.set_pins({6'h00, 2'(i), 1'b1});
      w(8);
      `CHK(torque_cmd, pv[i])
    end
    `CHK(mode_act, 1'b1)
    $display("test presets done");
    u_host.set_pins(9'h025);
    w(8);
    `CHK(torque_cmd, 16'h0000)
    u_host.set_pins(9'h045);
    w(8);
    `CHK(torque_cmd, 16'hff6a)
    u_host.set_pins(9'h065);
    w(8);
    `CHK(torque_cmd, 16'h0000)
    u_host.set_pins(9'h004);
    w(8);
    `CHK(torque_cmd, 16'h0000)
    $display("test inhibit done");
    u_host.set_pins(9'h005);
    wr(`TMCS_R_SCAP, 16'h03e8);
    u_host.set_fb(16'h0000, 16'h05dc);
    w(8);
    `CHK(torque_cmd, 16'h0000)
    `CHK(limited, 1'b1)
    `CHK(speed_limit, 16'h03e8)
    rc(`TMCS_R_STAT, 16'h0065);
    rc(`TMCS_R_TCMD, 16'h0000);
    wr(`TMCS_R_SPD1, 16'h01f4);
    wr(`TMCS_R_SLSEL, 16'h0002);
    w(6);
    `CHK(speed_limit, 16'h01f4)
    wr(5'(`TMCS_R_SPD1 + 1), 16'h0190);
    u_host.set_pins(9'h00d);
    w(6);
    `CHK(speed_limit, 16'h0190)
    wr(5'(`TMCS_R_SPD1 + 3), 16'h012c);
    u_host.set_pins(9'h01d);
    w(6);
    `CHK(speed_limit, 16'h012c)
    wr(`TMCS_R_SLSEL, 16'h0001);
    u_host.set_ana(18'h00190, 18'h00000);
    w(8);
    `CHK(speed_limit, 16'h00c8)
    u_host.set_fb(16'h0000, 16'h0000);
    w(8);
    `CHK(limited, 1'b0)
    `CHK(torque_cmd, 16'h0096)
    wr(`TMCS_R_MODE, 16'h0000);
    w(4);
    `CHK(mode_act, 1'b0)
    `CHK(torque_cmd, 16'h0000)
    wr(`TMCS_R_MODE, `TMCS_MODE_TORQUE);
    $display("test speed cap done");
    wr(`TMCS_R_RTHR, 16'h0032);
    wr(`TMCS_R_RHYS, 16'h000a);
    u_host.set_fb(16'h003c, 16'h0000);
    w(4);
    `CHK(reached, 1'b1)
    u_host.set_fb(16'h002d, 16'h0000);
    w(4);
    `CHK(reached, 1'b1)
    u_host.set_fb(16'h0023, 16'h0000);
    w(4);
    `CHK(reached, 1'b0)
    wr(`TMCS_R_RPOL, 16'h0001);
    w(4);
    `CHK(reached, 1'b1)
    $display("test reach done");
    wr(`TMCS_R_IGNOT, 16'h0000);
    u_host.set_pins(9'h085);
    w(8);
    `CHK(fproh, 1'b1)
    `CHK(torque_cmd, 16'h0000)
    u_host.set_pins(9'h105);
    w(8);
    `CHK({fproh, rproh}, 2'b01)
    `CHK(torque_cmd, 16'h0096)
    wr(`TMCS_R_IGNOT, 16'h0003);
    u_host.set_pins(9'h185);
    w(8);
    `CHK({fproh, rproh}, 2'b00)
    $display("test overtravel done");
    u_host.set_pins(9'h001);
    wr(`TMCS_R_SLSEL, 16'h0000);
    wr(`TMCS_R_SRC, 16'h0000);
    wr(`TMCS_R_TAU, 16'h0014);
    u_host.set_ana(18'h007d0, 18'h003e8);
    w(30000);
    `CHK(torque_cmd >= 16'sd28 && torque_cmd <= 16'sd30, 1'b1)
    wr(`TMCS_R_DIRPOL, 16'h0001);
    w(8);
    `CHK(torque_cmd >= -16'sd30 && torque_cmd <= -16'sd28, 1'b1)
    wr(`TMCS_R_DIRPOL, 16'h0004);
    w(8);
    `CHK(torque_cmd, 16'h0000)
    wr(`TMCS_R_DIRPOL, 16'h0000);
    wr(`TMCS_R_CHAN, 16'h0001);
    w(8);
    `CHK(torque_cmd, 16'h003c)
    wr(`TMCS_R_CHAN, 16'h0000);
    wr(`TMCS_R_SRC, 16'h0002);
    w(8);
    `CHK(torque_cmd >= 16'sd28 && torque_cmd <= 16'sd30, 1'b1)
    u_host.set_pins(9'h003);
    w(8);
    `CHK(torque_cmd, 16'hffec)
    u_host.set_pins(9'h001);
    wr(`TMCS_R_OFF2, 16'hd8f0);
    w(2000);
    `CHK(torque_cmd >= 16'sd18 && torque_cmd <= 16'sd21, 1'b1)
    wr(`TMCS_R_DZONE, 16'h07d0);
    w(8);
    `CHK(torque_cmd, 16'h0000)
    $display("test analog done");
    u_host.set_ana(18'h0007b, 18'h3ffd3);
    wr(`TMCS_R_CAL, `TMCS_CAL_AS1);
    rc(`TMCS_R_CAL1, 16'hff85);
    wr(`TMCS_R_CAL, `TMCS_CAL_AS2);
    rc(`TMCS_R_CAL2, 16'h002d);
    $display("test calibration done");
    complete_run();
  end
endmodule : tb
